// [hdl/crc_ctrl_end.sv]
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
// Contract
// - CRC-8 x^8+x^2+x+1, 72 bits, zero start
// - All check bits from parallel XOR taps
// - Controller checksums and frames every write
// - x8: all data lanes ones in transfer 9
// - x8: inversion lane ones in transfers 8, 9
// - x16: same fills on both halves
// - Device recomputes, mismatch raises alert
// - x8: top eight inputs ones unless lane used
// - Never inversion and mask together
// - x16: two trees, same top padding
// - x4: 32 data inputs, upper 40 ones
// - Device commits data before check ends
// - Controller reissues write after error alert
// - x4 lane n: bits 8n.., CRC n, n+4
// - x8 lane n: bits 8n.., CRC n
// - x16 is two x8 halves
// - CRC frames last ten transfers
// - Error is low alert pulse, six clocks
// - Sticky error flag until host clears
module crc_ctrl_end (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	crc_link_if.ctrl         link
);

	typedef enum logic {
		IDLE = 1'b0,
		SEND = 1'b1
	} state_t;

	state_t          state_r;
	logic [31:0]     cfg_r;
	logic [31:0]     data_r [crc_pkg::DATA_WORDS];
	logic [31:0]     dat_r;
	logic            ack_r;
	logic            err_seen_r;
	logic            retry_r;
	logic            have_frame_r;
	logic            alert_d_r;
	logic            clear_r;
	logic [143:0]    frame_r;
	logic [7:0]      crc_lo_r;
	logic [7:0]      crc_hi_r;
	logic [3:0]      beat_r;
	crc_pkg::width_t width_r;
	logic            crc_en_r;
	logic            dbi_r;
	logic            dm_r;
	logic            valid_r;
	logic            first_r;
	logic [15:0]     dq_r;
	logic            lo_lane_r;
	logic            hi_lane_r;

	logic            req;
	logic            wr_take;
	logic            start_cmd;
	logic            launch;
	logic            alert_fall;
	logic [31:0]     rd_val;
	logic [143:0]    data_word;
	crc_pkg::width_t cfg_w;
	logic            cfg_dbi;
	logic            cfg_dm;
	logic [3:0]      last;
	logic [15:0]     dq_nxt;
	logic            lo_nxt;
	logic            hi_nxt;
	logic            x4;
	logic            x16;
	logic            in_data;
	logic            lane_on;

	function automatic logic [31:0] sel_merge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0]  sel
	);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				m[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return m;
	endfunction : sel_merge

	function automatic logic data_hit(input logic [7:0] adr);
		return adr >= crc_pkg::ADR_DATA && adr < crc_pkg::ADR_DATA_END &&
			adr[1:0] == 2'h0;
	endfunction : data_hit

	function automatic logic [2:0] data_idx(input logic [7:0] adr);
		logic [7:0] off;
		off = adr - crc_pkg::ADR_DATA;
		return off[4:2];
	endfunction : data_idx

	assign req        = wb_cyc_i & wb_stb_i;
	assign wr_take    = req & wb_we_i & ack_r;
	assign start_cmd  = wr_take & (wb_adr_i == crc_pkg::ADR_CMD) &
		wb_sel_i[0] & wb_dat_i[crc_pkg::CMD_START];
	assign launch     = (state_r == IDLE) & (start_cmd | retry_r);
	assign alert_fall = alert_d_r & ~link.alert_n;
	assign wb_dat_o   = dat_r;
	assign wb_ack_o   = ack_r;

	assign data_word = {data_r[4][15:0], data_r[3], data_r[2],
		data_r[1], data_r[0]};
	assign cfg_w   = crc_pkg::width_t'(cfg_r[1:0]);
	assign cfg_dbi = cfg_r[crc_pkg::CFG_DBI];
	assign cfg_dm  = cfg_r[crc_pkg::CFG_DM] & ~cfg_dbi;

	// Register read mux
	always_comb begin
		rd_val = 32'h0000_0000;
		if (wb_adr_i == crc_pkg::ADR_CFG) begin
			rd_val = cfg_r;
		end else if (wb_adr_i == crc_pkg::ADR_STAT) begin
			rd_val[0] = state_r == SEND;
			rd_val[1] = err_seen_r;
			rd_val[2] = retry_r;
		end else if (data_hit(wb_adr_i)) begin
			rd_val = data_r[data_idx(wb_adr_i)];
		end
	end

	// Bus answer one cycle after the request
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ack_r <= 1'h0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= req & ~ack_r;
			if (req && !ack_r) begin
				dat_r <= rd_val;
			end
		end
	end

	// Configuration and frame data registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cfg_r <= crc_pkg::CFG_RESET;
			for (int i = 0; i < crc_pkg::DATA_WORDS; i++) begin
				data_r[i] <= 32'h0000_0000;
			end
		end else if (wr_take) begin
			if (wb_adr_i == crc_pkg::ADR_CFG) begin
				cfg_r <= sel_merge(cfg_r, wb_dat_i, wb_sel_i) &
					crc_pkg::CFG_MASK;
			end else if (data_hit(wb_adr_i)) begin
				data_r[data_idx(wb_adr_i)] <= sel_merge(
					data_r[data_idx(wb_adr_i)], wb_dat_i, wb_sel_i) &
					((data_idx(wb_adr_i) == crc_pkg::DATA_TOP) ?
					crc_pkg::DATA_TOP_MASK : 32'hffff_ffff);
			end
		end
	end

	// Alert watch, retry request and device error clear
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			alert_d_r  <= 1'h1;
			err_seen_r <= 1'h0;
			retry_r    <= 1'h0;
			clear_r    <= 1'h0;
		end else begin
			alert_d_r <= link.alert_n;
			clear_r   <= wr_take & (wb_adr_i == crc_pkg::ADR_CMD) &
				wb_sel_i[0] & wb_dat_i[crc_pkg::CMD_CLEAR];
			if (alert_fall) begin
				err_seen_r <= 1'h1;
			end else if (clear_r) begin
				err_seen_r <= 1'h0;
			end
			if (alert_fall && cfg_r[crc_pkg::CFG_RETRY] && have_frame_r) begin
				retry_r <= 1'h1;
			end else if (launch) begin
				retry_r <= 1'h0;
			end
		end
	end

	// Frame launch and beat sequencing
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_r      <= IDLE;
			beat_r       <= 4'h0;
			have_frame_r <= 1'h0;
			frame_r      <= 144'h0;
			crc_lo_r     <= 8'h00;
			crc_hi_r     <= 8'h00;
			width_r      <= crc_pkg::W_X8;
			crc_en_r     <= 1'h0;
			dbi_r        <= 1'h0;
			dm_r         <= 1'h0;
		end else begin
			unique case (state_r)
			IDLE: begin
				beat_r <= 4'h0;
				if (launch) begin
					state_r      <= SEND;
					have_frame_r <= 1'h1;
				end
				if (launch && !retry_r) begin
					frame_r  <= data_word;
					width_r  <= cfg_w;
					crc_en_r <= cfg_r[crc_pkg::CFG_CRC];
					dbi_r    <= cfg_dbi;
					dm_r     <= cfg_dm;
					crc_lo_r <= crc_pkg::next_check_bits(crc_pkg::pad_word(
						data_word[71:0], cfg_w,
						cfg_dbi | cfg_dm));
					crc_hi_r <= crc_pkg::next_check_bits(crc_pkg::pad_word(
						data_word[143:72], cfg_w,
						cfg_dbi | cfg_dm));
				end
			end
			SEND: begin
				beat_r <= beat_r + 4'h1;
				if (beat_r == last) begin
					state_r <= IDLE;
				end
			end
			endcase
		end
	end

	assign last    = crc_en_r ? crc_pkg::LAST_CRC : crc_pkg::LAST_DATA;
	assign x4      = width_r == crc_pkg::W_X4;
	assign x16     = width_r == crc_pkg::W_X16;
	assign in_data = beat_r <= crc_pkg::LAST_DATA;
	assign lane_on = dbi_r | dm_r;

	// Lane contents for the current transfer
	for (genvar n = 0; n < 8; n++) begin : g_lane
		logic [7:0] byte_lo;
		logic [7:0] byte_hi;
		assign byte_lo = frame_r[8*n +: 8];
		assign byte_hi = frame_r[72+8*n +: 8];
		if (n < 4) begin : g_lo
			assign dq_nxt[n] = in_data ? byte_lo[beat_r[2:0]] :
				(beat_r == crc_pkg::BEAT_CRC) ? crc_lo_r[n] :
				x4 ? crc_lo_r[n+4] : 1'h1;
		end else begin : g_hi
			assign dq_nxt[n] = x4 ? 1'h1 :
				in_data ? byte_lo[beat_r[2:0]] :
				(beat_r == crc_pkg::BEAT_CRC) ? crc_lo_r[n] :
				1'h1;
		end
		assign dq_nxt[8+n] = !x16 ? 1'h1 :
			in_data ? byte_hi[beat_r[2:0]] :
			(beat_r == crc_pkg::BEAT_CRC) ? crc_hi_r[n] :
			1'h1;
	end

	assign lo_nxt = (in_data && lane_on && !x4) ?
		frame_r[64 + beat_r[2:0]] : 1'h1;
	assign hi_nxt = (in_data && lane_on && x16) ?
		frame_r[136 + beat_r[2:0]] : 1'h1;

	// Link drive, one transfer per clock
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			valid_r   <= 1'h0;
			first_r   <= 1'h0;
			dq_r      <= 16'hffff;
			lo_lane_r <= 1'h1;
			hi_lane_r <= 1'h1;
		end else begin
			valid_r   <= state_r == SEND;
			first_r   <= (state_r == SEND) && (beat_r == 4'h0);
			dq_r      <= (state_r == SEND) ? dq_nxt : 16'hffff;
			lo_lane_r <= (state_r == SEND) ? lo_nxt : 1'h1;
			hi_lane_r <= (state_r == SEND) ? hi_nxt : 1'h1;
		end
	end

	assign link.beat_valid             = valid_r;
	assign link.beat_first             = first_r;
	assign link.dq                     = dq_r;
	assign link.lower_mask_invert_lane = lo_lane_r;
	assign link.upper_mask_invert_lane = hi_lane_r;
	assign link.width                  = width_r;
	assign link.crc_en                 = crc_en_r;
	assign link.dbi_en                 = dbi_r;
	assign link.dm_en                  = dm_r;
	assign link.err_clear              = clear_r;

endmodule : crc_ctrl_end

// [hdl/crc_pkg.sv]
package crc_pkg;

	typedef enum logic [1:0] {
		W_X4  = 2'b00,
		W_X8  = 2'b01,
		W_X16 = 2'b10
	} width_t;

	// Frame shape
	localparam int         BEATS     = 10;
	localparam int         LANE_BITS = 18;
	localparam int         CRC_IDX   = 8;
	localparam int         FILL_IDX  = 9;
	localparam logic [3:0] LAST_DATA = 4'h7;
	localparam logic [3:0] BEAT_CRC  = 4'h8;
	localparam logic [3:0] LAST_CRC  = 4'h9;

	// Alert pulse width in clocks
	localparam logic [3:0] ALERT_PW_CYC = 4'h6;

	localparam logic [7:0]  ONES8  = 8'hff;
	localparam logic [39:0] ONES40 = 40'hff_ffff_ffff;

	// Each check bit is the parity of its tap set
	localparam logic [71:0] CHECK_MASK [8] = '{
		72'h3D_9177_298C_D0AD_51C1,
		72'h46_B399_7A95_71F7_F243,
		72'hB0_F645_DCA6_3342_B547,
		72'h61_EC8B_B94C_6685_6A8E,
		72'hC3_D917_7298_CD0A_D51C,
		72'h87_B22E_E531_9A15_AA38,
		72'h0F_645D_CA63_342B_5470,
		72'h1E_C8BB_94C6_6856_A8E0
	};

	// Controller register map
	localparam logic [7:0]  ADR_CFG      = 8'h00;
	localparam logic [7:0]  ADR_CMD      = 8'h04;
	localparam logic [7:0]  ADR_STAT     = 8'h08;
	localparam logic [7:0]  ADR_DATA     = 8'h10;
	localparam logic [7:0]  ADR_DATA_END = 8'h24;
	localparam int          DATA_WORDS   = 5;
	localparam logic [2:0]  DATA_TOP     = 3'h4;
	localparam logic [31:0] DATA_TOP_MASK = 32'h0000_ffff;
	localparam logic [31:0] CFG_RESET    = 32'h0000_0005;
	localparam logic [31:0] CFG_MASK     = 32'h0000_003f;
	localparam int          CFG_CRC      = 2;
	localparam int          CFG_DBI      = 3;
	localparam int          CFG_DM       = 4;
	localparam int          CFG_RETRY    = 5;
	localparam int          CMD_START    = 0;
	localparam int          CMD_CLEAR    = 1;

	function automatic logic [7:0] next_check_bits(
		input logic [71:0] d
	);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 8; i++) begin
			c[i] = ^(d & CHECK_MASK[i]);
		end
		return c;
	endfunction : next_check_bits

	function automatic logic [71:0] pad_word(
		input logic [71:0] d,
		input width_t      w,
		input logic        lane_on
	);
		logic [71:0] p;
		p = d;
		if (w == W_X4) begin
			p[71:32] = ONES40;
		end else if (!lane_on) begin
			p[71:64] = ONES8;
		end
		return p;
	endfunction : pad_word

endpackage : crc_pkg

// [hdl/crc_link_if.sv]
`timescale 1ns/100ps
interface crc_link_if;
	logic                beat_valid;
	logic                beat_first;
	logic [15:0]         dq;
	logic                lower_mask_invert_lane;
	logic                upper_mask_invert_lane;
	crc_pkg::width_t     width;
	logic                crc_en;
	logic                dbi_en;
	logic                dm_en;
	logic                err_clear;
	logic                alert_o;
	logic                alert_oe;
	logic                alert_n;

	// Open drain with pull-up
	assign alert_n = alert_oe ? alert_o : 1'h1;

	modport ctrl (
		output beat_valid,
		output beat_first,
		output dq,
		output lower_mask_invert_lane,
		output upper_mask_invert_lane,
		output width,
		output crc_en,
		output dbi_en,
		output dm_en,
		output err_clear,
		input  alert_n
	);

	modport dram (
		input  beat_valid,
		input  beat_first,
		input  dq,
		input  lower_mask_invert_lane,
		input  upper_mask_invert_lane,
		input  width,
		input  crc_en,
		input  dbi_en,
		input  dm_en,
		input  err_clear,
		output alert_o,
		output alert_oe
	);
endinterface : crc_link_if

// [hdl/crc_dram_end.sv]
`timescale 1ns/100ps
module crc_dram_end (
	input  wire logic     clk,
	input  wire logic     rst_b,
	crc_link_if.dram      link,
	output logic [143:0]  wr_word_r,
	output logic          wr_valid_r,
	output logic          crc_err_r,
	output logic          err_flag_r
);

	logic [crc_pkg::LANE_BITS-1:0] cap_r [crc_pkg::BEATS];
	logic [3:0]   beat_cnt_r;
	logic [3:0]   pw_cnt_r;
	logic         check_go_r;
	logic         data_go_r;
	logic         alert_o_r;
	logic         alert_oe_r;
	logic [3:0]   idx;
	logic [3:0]   last;
	logic [143:0] word;
	logic [7:0]   rx_lo;
	logic [7:0]   rx_hi;
	logic [7:0]   calc_lo;
	logic [7:0]   calc_hi;
	logic         lane_on;
	logic         x4;
	logic         mismatch;

	assign idx     = link.beat_first ? 4'h0 : beat_cnt_r;
	assign last    = link.crc_en ? crc_pkg::LAST_CRC : crc_pkg::LAST_DATA;
	assign lane_on = link.dbi_en | link.dm_en;
	assign x4      = link.width == crc_pkg::W_X4;
	assign link.alert_o  = alert_o_r;
	assign link.alert_oe = alert_oe_r;

	// Beat position tracking
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			beat_cnt_r <= 4'h0;
			check_go_r <= 1'h0;
			data_go_r  <= 1'h0;
		end else begin
			check_go_r <= link.beat_valid & link.crc_en &
				(idx == crc_pkg::LAST_CRC);
			data_go_r  <= link.beat_valid & (idx == crc_pkg::LAST_DATA);
			if (link.beat_valid) begin
				beat_cnt_r <= (idx == last) ? 4'h0 : idx + 4'h1;
			end
		end
	end

	// Frame capture, data path only
	always_ff @(posedge clk) begin
		if (link.beat_valid && idx <= crc_pkg::LAST_CRC) begin
			cap_r[idx] <= {link.upper_mask_invert_lane,
				link.lower_mask_invert_lane, link.dq};
		end
	end

	// Lane n, transfer t holds code bit 8n+t
	for (genvar n = 0; n < 8; n++) begin : g_lane
		for (genvar t = 0; t < 8; t++) begin : g_xfer
			assign word[8*n+t]    = cap_r[t][n];
			assign word[72+8*n+t] = cap_r[t][8+n];
		end
		assign word[64+n]  = cap_r[n][16];
		assign word[136+n] = cap_r[n][17];
		assign rx_hi[n] = cap_r[crc_pkg::CRC_IDX][8+n];
		if (n < 4) begin : g_lo
			assign rx_lo[n] = cap_r[crc_pkg::CRC_IDX][n];
		end else begin : g_hi
			assign rx_lo[n] = x4 ? cap_r[crc_pkg::FILL_IDX][n-4] :
				cap_r[crc_pkg::CRC_IDX][n];
		end
	end

	// Padding and check trees
	assign calc_lo = crc_pkg::next_check_bits(crc_pkg::pad_word(
		word[71:0], link.width, lane_on));
	assign calc_hi = crc_pkg::next_check_bits(crc_pkg::pad_word(
		word[143:72], link.width, lane_on));
	assign mismatch = (calc_lo != rx_lo) |
		((link.width == crc_pkg::W_X16) & (calc_hi != rx_hi));

	// Write commit does not wait for the check
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wr_valid_r <= 1'h0;
			wr_word_r  <= 144'h0;
		end else begin
			wr_valid_r <= data_go_r;
			if (data_go_r) begin
				wr_word_r <= word;
			end
		end
	end

	// One error verdict per frame
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			crc_err_r <= 1'h0;
		end else begin
			crc_err_r <= check_go_r & mismatch;
		end
	end

	// Low pulse on the shared alert line
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pw_cnt_r   <= 4'h0;
			alert_oe_r <= 1'h0;
			alert_o_r  <= 1'h0;
		end else begin
			alert_o_r <= 1'h0;
			if (check_go_r && mismatch) begin
				pw_cnt_r   <= crc_pkg::ALERT_PW_CYC;
				alert_oe_r <= 1'h1;
			end else if (pw_cnt_r != 4'h0) begin
				pw_cnt_r <= pw_cnt_r - 4'h1;
				if (pw_cnt_r == 4'h1) begin
					alert_oe_r <= 1'h0;
				end
			end
		end
	end

	// Sticky error flag, a new error beats the clear
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			err_flag_r <= 1'h0;
		end else if (check_go_r && mismatch) begin
			err_flag_r <= 1'h1;
		end else if (link.err_clear) begin
			err_flag_r <= 1'h0;
		end
	end

endmodule : crc_dram_end

// [dv/crc_link_checker.sv]
`timescale 1ns/100ps
module crc_link_checker (
	input wire logic            clk,
	input wire logic            rst_b,
	input wire logic            beat_valid,
	input wire logic            beat_first,
	input wire logic [15:0]     dq,
	input wire logic            lower_mask_invert_lane,
	input wire logic            upper_mask_invert_lane,
	input wire crc_pkg::width_t width,
	input wire logic            crc_en,
	input wire logic            dbi_en,
	input wire logic            dm_en,
	input wire logic            alert_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_ten;
		beat_valid [*8] ##1 beat_valid [*2] ##1 !beat_valid;
	endsequence
	sequence s_eight;
		beat_valid [*8] ##1 !beat_valid;
	endsequence
	sequence s_fill8;
		lower_mask_invert_lane ##1 (lower_mask_invert_lane && dq == 16'hffff);
	endsequence
	sequence s_fill16;
		(lower_mask_invert_lane && upper_mask_invert_lane)
		##1 (lower_mask_invert_lane && upper_mask_invert_lane
		&& dq == 16'hffff);
	endsequence
	chk_crc_frame_len: assert property (
		beat_first && crc_en |-> s_ten) else $error("crc frame length");
	chk_plain_frame_len: assert property (
		beat_first && !crc_en |-> s_eight) else $error("plain frame length");
	chk_x8_fill: assert property (
		beat_first && crc_en && width == crc_pkg::W_X8 |-> ##8 s_fill8)
		else $error("x8 fill beats wrong");
	chk_x16_fill: assert property (
		beat_first && crc_en && width == crc_pkg::W_X16 |-> ##8 s_fill16)
		else $error("x16 fill beats wrong");
	chk_first_once: assert property (
		beat_first |-> beat_valid ##1 (beat_valid && !beat_first) [*7])
		else $error("frame start marker wrong");
	chk_x4_lanes: assert property (
		beat_valid && width == crc_pkg::W_X4 |-> dq[15:4] == 12'hfff)
		else $error("x4 unused lanes not high");
	chk_x8_upper: assert property (
		beat_valid && width == crc_pkg::W_X8
		|-> dq[15:8] == 8'hff && upper_mask_invert_lane)
		else $error("x8 upper lanes not high");
	chk_lane_pad: assert property (
		beat_valid && !dbi_en && !dm_en |-> lower_mask_invert_lane
		&& upper_mask_invert_lane) else $error("unused lane not high");
	chk_mode_excl: assert property (
		beat_valid |-> !(dbi_en && dm_en)) else $error("inversion and mask");
	chk_alert_width: assert property (
		$rose(alert_oe) |-> alert_oe [*6] ##1 !alert_oe)
		else $error("alert pulse width");
	chk_alert_cause: assert property (
		$rose(alert_oe) |-> $past(beat_valid, 2) && !$past(beat_valid))
		else $error("alert not after frame end");
endmodule : crc_link_checker

// [dv/write_data_crc_check_tb.sv]
`timescale 1ns/100ps
module write_data_crc_check_tb;
	typedef struct packed {
		crc_pkg::width_t w;
		logic            crc, dbi, dm;
		logic [15:0]     s;
	} row_t;
	logic        clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000, rdat;
	wire logic [31:0] q;
	wire logic        ack, wv1, ce1, ef1, wv2, ce2, ef2;
	wire logic [143:0] w1, w2;
	logic [143:0] got1, got2;
	logic [17:0]  beats [10];
	int n_errors = 0, check_count = 0, cyc_n = 0, nb = 0, nfr = 0;
	int nerr1 = 0, nerr2 = 0, low = 0, lmax = 0, e0;
	crc_link_if crc_link_if_i ();
	crc_link_if probe_link_if_i ();
	crc_ctrl_end crc_ctrl_end_i (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(4'hf), .wb_dat_o(q), .wb_ack_o(ack), .link(crc_link_if_i));
	crc_dram_end crc_dram_end_i (.clk(clk), .rst_b(rst_b),
		.link(crc_link_if_i), .wr_word_r(w1), .wr_valid_r(wv1),
		.crc_err_r(ce1), .err_flag_r(ef1));
	crc_dram_end probe_dram_end_i (.clk(clk), .rst_b(rst_b),
		.link(probe_link_if_i), .wr_word_r(w2), .wr_valid_r(wv2),
		.crc_err_r(ce2), .err_flag_r(ef2));
	crc_link_checker crc_link_checker_i (.clk(clk), .rst_b(rst_b),
		.beat_valid(crc_link_if_i.beat_valid),
		.beat_first(crc_link_if_i.beat_first), .dq(crc_link_if_i.dq),
		.lower_mask_invert_lane(crc_link_if_i.lower_mask_invert_lane),
		.upper_mask_invert_lane(crc_link_if_i.upper_mask_invert_lane),
		.width(crc_link_if_i.width), .crc_en(crc_link_if_i.crc_en),
		.dbi_en(crc_link_if_i.dbi_en), .dm_en(crc_link_if_i.dm_en),
		.alert_oe(crc_link_if_i.alert_oe));
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		if (crc_link_if_i.beat_valid) begin
			if (crc_link_if_i.beat_first) nb = 0;
			if (crc_link_if_i.beat_first) nfr++;
			if (nb < 10) beats[nb] = {crc_link_if_i.upper_mask_invert_lane,
				crc_link_if_i.lower_mask_invert_lane, crc_link_if_i.dq};
			nb++;
		end
		if (wv1) got1 = w1;
		if (wv2) got2 = w2;
		if (ce1) nerr1++;
		if (ce2) nerr2++;
		if (!probe_link_if_i.alert_n) low++;
		else if (low != 0) lmax = low;
		if (probe_link_if_i.alert_n) low = 0;
		cyc_n++;
		if (cyc_n == 6000) begin
			n_errors++;
			results();
		end
	end
	function automatic logic [7:0] crc8(logic [71:0] d);
		logic [7:0] c;
		logic       fb;
		c = 8'h00;
		for (int i = 71; i >= 0; i--) begin
			fb = c[7] ^ d[i];
			c = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
		end
		return c;
	endfunction : crc8
	function automatic logic [143:0] pad(row_t r);
		logic [143:0] p;
		p = {9{r.s}} ^ {3{48'h9e37_79b9_7f4a}};
		if (r.w != crc_pkg::W_X16) p[143:72] = {72{1'b1}};
		if (r.w == crc_pkg::W_X4) p[71:32] = {40{1'b1}};
		else if (!(r.dbi || r.dm)) p[71:64] = 8'hff;
		if (r.w != crc_pkg::W_X4 && !(r.dbi || r.dm)) p[143:136] = 8'hff;
		return p;
	endfunction : pad
	function automatic logic [17:0] beat(row_t r, int t);
		logic [143:0] p;
		logic [17:0]  b;
		logic [7:0]   c;
		p = pad(r);
		c = crc8(p[71:0]);
		b = 18'h3_ffff;
		if (t < 8) begin
			for (int n = 0; n < 8; n++) begin
				b[n] = p[8*n+t];
				b[n+8] = p[72+8*n+t];
			end
			b[16] = p[64+t];
			b[17] = p[136+t];
		end else if (t == 8) begin
			b[7:0] = c;
			if (r.w == crc_pkg::W_X16) b[15:8] = crc8(p[143:72]);
			if (r.w == crc_pkg::W_X4) b[7:4] = 4'hf;
		end else if (r.w == crc_pkg::W_X4) b[3:0] = c[7:4];
		return b;
	endfunction : beat
	task automatic chk(logic [143:0] got, logic [143:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rdat = q;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic wait_idle();
		do begin
			wb(1'b0, crc_pkg::ADR_STAT, 32'h0000_0000);
		end while (rdat[0] !== 1'b0);
		repeat (3) @(posedge clk);
	endtask : wait_idle
	task automatic run(row_t r);
		logic [143:0] p;
		p = pad(r);
		for (int i = 0; i < 4; i++)
			wb(1'b1, crc_pkg::ADR_DATA + 8'(4 * i), p[32*i +: 32]);
		wb(1'b1, crc_pkg::ADR_DATA + 8'h10, {16'h0000, p[143:128]});
		wb(1'b1, crc_pkg::ADR_CFG, {26'h0, 1'b0, r.dm, r.dbi, r.crc, r.w});
		wb(1'b1, crc_pkg::ADR_CMD, 32'h0000_0001);
		wait_idle();
		chk(got1, p);
		chk(nb, r.crc ? 10 : 8);
		for (int t = 0; t < 10 && t < nb; t++)
			chk(beats[t], beat(r, t));
		chk(nerr1, 0);
	endtask : run
	task automatic drive(row_t r, logic [17:0] flip);
		probe_link_if_i.width <= r.w;
		probe_link_if_i.crc_en <= 1'b1;
		probe_link_if_i.dbi_en <= r.dbi;
		for (int t = 0; t < 10; t++) begin
			{probe_link_if_i.upper_mask_invert_lane,
				probe_link_if_i.lower_mask_invert_lane, probe_link_if_i.dq}
				<= beat(r, t) ^ (t == 3 ? flip : 18'h0_0000);
			probe_link_if_i.beat_valid <= 1'b1;
			probe_link_if_i.beat_first <= (t == 0);
			@(posedge clk);
		end
		probe_link_if_i.beat_valid <= 1'b0;
		probe_link_if_i.beat_first <= 1'b0;
		probe_link_if_i.dq <= 16'hffff;
		repeat (12) @(posedge clk);
	endtask : drive
	task automatic results();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	row_t rows [8] = '{
		'{crc_pkg::W_X4, 1'b1, 1'b0, 1'b0, 16'h0000},
		'{crc_pkg::W_X8, 1'b1, 1'b0, 1'b0, 16'hc3a5},
		'{crc_pkg::W_X8, 1'b1, 1'b1, 1'b0, 16'h5a0f},
		'{crc_pkg::W_X8, 1'b1, 1'b0, 1'b1, 16'hffff},
		'{crc_pkg::W_X16, 1'b1, 1'b0, 1'b0, 16'h1234},
		'{crc_pkg::W_X16, 1'b1, 1'b1, 1'b0, 16'hbeef},
		'{crc_pkg::W_X16, 1'b1, 1'b1, 1'b1, 16'h7e81},
		'{crc_pkg::W_X8, 1'b0, 1'b0, 1'b0, 16'h0f0f}};
	initial begin
		{probe_link_if_i.beat_valid, probe_link_if_i.beat_first} = 2'h0;
		{probe_link_if_i.dm_en, probe_link_if_i.err_clear} = 2'h0;
		{probe_link_if_i.upper_mask_invert_lane,
			probe_link_if_i.lower_mask_invert_lane} = 2'h3;
		probe_link_if_i.dq = 16'hffff;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		chk({ef1, crc_link_if_i.dq}, 17'h0_ffff);
		wb(1'b0, crc_pkg::ADR_CFG, 32'h0000_0000);
		chk(rdat, crc_pkg::CFG_RESET);
		wb(1'b1, crc_pkg::ADR_CFG, 32'hffff_ffff);
		wb(1'b0, crc_pkg::ADR_CFG, 32'h0000_0000);
		chk(rdat, crc_pkg::CFG_MASK);
		wb(1'b1, 8'h40, 32'hffff_ffff);
		wb(1'b0, 8'h40, 32'h0000_0000);
		chk(rdat, 32'h0000_0000);
		for (int i = 0; i < 8; i++)
			run(rows[i]);
		e0 = nfr;
		wb(1'b1, crc_pkg::ADR_CMD, 32'h0000_0001);
		wb(1'b1, crc_pkg::ADR_CMD, 32'h0000_0001);
		wait_idle();
		chk(nfr - e0, 1);
		e0 = nerr2;
		drive(rows[2], 18'h0_0004);
		chk(got2, pad(rows[2]) ^ (144'h1 << 19));
		chk({nerr2 - e0, lmax, ef2}, {32'd1, 32'd6, 1'b1});
		probe_link_if_i.err_clear <= 1'b1;
		@(posedge clk);
		probe_link_if_i.err_clear <= 1'b0;
		repeat (2) @(posedge clk);
		chk(ef2, 1'b0);
		drive(rows[1], 18'h1_0000);
		drive(rows[0], 18'h0_0020);
		chk(nerr2 - e0, 1);
		// Inversion lane in use: a flipped lane bit must be caught
		drive(rows[2], 18'h1_0000);
		chk({nerr2 - e0, ef2}, {32'd2, 1'b1});
		// Mid-run reset drops the sticky flag
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		chk({ef2, ack, crc_link_if_i.dq}, 18'h0_ffff);
		results();
	end
endmodule : write_data_crc_check_tb
